// [rtl/tfp_fan_ctrl.sv]
// Temperature driven fan PWM controller with fault detect, overheat alert and register slave
// Functional notes
// (R1) Stored junction temperature compared with threshold set to pick drive level.
// (R2) Six thresholds: minimum, full, four equally spaced between them.
// (R3) Minimum-speed variant: 40% below lowest, 50..90% per band, 100% at full.
// (R4) Auto-shutdown variant: output off below minimum, otherwise same duty steps.
// (R5) PWM near 15Hz; its period is the start-up timer timebase.
// (R6) Starting from off forces drive high for about two seconds.
// (R7) Alert goes low, duty 100%, once temperature exceeds full threshold by 10.
// (R8) Sense pulses caused by PWM turn-on are blanked before detection.
// (R9) Missing pulses only checked outside shutdown.
// (R10) First missing-pulse detection retriggers start-up once; fault only if persisting.
// (R11) No pulses for 32 PWM periods: PWM low, fault output asserted.
// (R12) After fault stay latched in shutdown with PWM low until released.
// (R13) Toggling shutdown input or power cycle clears fault and leaves shutdown.
// (R14) Fault output stays high while in shutdown.
// (R15) Temperature monitoring and alert continue during shutdown.
// (R16) Shutdown input asserted holds PWM low and fault output high.
// (R17) Alert released only when temperature falls 5 below the trip point.
// (R18) Thresholds and variant are static parameters; temperature arrives as a code.
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module tfp_fan_ctrl
#(
    parameter logic signed [7:0] LOW_THRESHOLD = 8'sh19,
    parameter logic signed [7:0] FULL_THRESHOLD = 8'sh2D,
    parameter bit AUTO_SHUTDOWN = 1'b0,
    parameter int SLOT_CYCLES = tfp_pkg::SLOT_CYC
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Temperature code from the sensing front end
    input wire logic signed [tfp_pkg::TEMP_W-1:0] junction_temperature,
    input wire logic tempValid,
    // Fan link
    input wire logic senseIn,
    input wire logic shutdown_request_n,
    output logic pwmOut,
    output logic faultOut_n,
    output logic overheatAlert_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Interrupt
    output logic irq
);
    import tfp_pkg::*;

    logic signed [TEMP_W-1:0] tempHold_ff;
    logic [SLOT_W-1:0] slotCnt_ff;
    logic [3:0] slotIdx_ff;
    logic [3:0] duty_ff;
    tfp_state_t state_ff;
    tfp_state_t nxt_state;
    logic [5:0] periodCnt_ff;
    logic [5:0] missCnt_ff;
    logic shdnPrev_ff;
    logic pwmPrev_ff;
    logic overheat_ff;
    logic [EV_W-1:0] status_ff;
    logic [EV_W-1:0] mask_ff;
    logic [EV_W-1:0] evSet;
    logic ackPending_ff;
    logic [3:0] nxt_duty;
    logic periodEnd;
    logic shutdownPin;
    logic senseValid;
    logic drive;
    logic signed [TEMP_W-1:0] tripPoint;
    logic signed [TEMP_W-1:0] releasePoint;

    // Threshold k of six: k=0 low, k=5 full, equal steps between
    function automatic logic signed [TEMP_W-1:0] thresh(input logic [2:0] k);
        logic signed [TEMP_W+3:0] span;
        span = 12'(FULL_THRESHOLD - LOW_THRESHOLD) * $signed({9'h000, k});
        thresh = TEMP_W'(LOW_THRESHOLD + TEMP_W'(span / 12'sh005));
    endfunction

    assign shutdownPin = ~shutdown_request_n;
    assign periodEnd = (slotCnt_ff == SLOT_W'(SLOT_CYCLES - 1)) && (slotIdx_ff == SLOT_LAST);
    assign tripPoint = FULL_THRESHOLD + OVERHEAT_OFFSET;
    assign releasePoint = tripPoint - OVERHEAT_HYST;

    // Latest temperature code is the compared register
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            tempHold_ff <= '0;
        else if (tempValid)
            tempHold_ff <= junction_temperature; // R1 R18
    end

    // Duty selection from the threshold bands
    always_comb
    begin
        nxt_duty = AUTO_SHUTDOWN ? DUTY_OFF : DUTY_MIN; // R3 R4
        for (int k = 0; k < 6; k++)
        begin
            if (tempHold_ff >= thresh(3'(k))) // R1 R2
                nxt_duty = DUTY_BAND0 + 4'(k); // R3
        end
    end

    // Duty is only adopted at period boundaries so a pulse never gets clipped
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            duty_ff <= DUTY_OFF;
        else if (periodEnd)
            duty_ff <= nxt_duty;
    end

    // Free-running PWM timebase: ten slots per ~15Hz period
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            slotCnt_ff <= '0;
            slotIdx_ff <= '0;
        end
        else if (slotCnt_ff == SLOT_W'(SLOT_CYCLES - 1))
        begin
            slotCnt_ff <= '0;
            slotIdx_ff <= (slotIdx_ff == SLOT_LAST) ? 4'h0 : slotIdx_ff + 4'h1; // R5
        end
        else
            slotCnt_ff <= slotCnt_ff + SLOT_W'(1);
    end

    // Overheat alert with hysteresis, runs even during shutdown
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            overheat_ff <= 1'b0;
        else if (tempHold_ff > tripPoint)
            overheat_ff <= 1'b1; // R7 R15
        else if (tempHold_ff <= releasePoint)
            overheat_ff <= 1'b0; // R17
    end

    // Fan state sequencing
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            TFP_OFF:
                if (!shutdownPin && nxt_duty != DUTY_OFF)
                    nxt_state = TFP_START; // R6
            TFP_START:
                if (shutdownPin)
                    nxt_state = TFP_OFF; // R16
                else if (periodEnd && periodCnt_ff == STARTUP_PERIODS - 6'h01)
                    nxt_state = TFP_RUN;
            TFP_RUN:
                if (shutdownPin)
                    nxt_state = TFP_OFF; // R16
                else if (duty_ff == DUTY_OFF && nxt_duty == DUTY_OFF)
                    nxt_state = TFP_OFF; // R4
                else if (periodEnd && missCnt_ff == MISS_PERIODS - 6'h01)
                    nxt_state = TFP_RETRY; // R10
            TFP_RETRY:
                if (shutdownPin)
                    nxt_state = TFP_OFF;
                else if (periodEnd && missCnt_ff == MISS_PERIODS - 6'h01)
                    nxt_state = TFP_FAULT; // R10 R11
                else if (periodEnd && periodCnt_ff == STARTUP_PERIODS - 6'h01 && missCnt_ff != periodCnt_ff)
                    nxt_state = TFP_RUN;
            TFP_FAULT:
                if (shutdownPin && !shdnPrev_ff)
                    nxt_state = TFP_OFF; // R12 R13
            default:
                nxt_state = TFP_OFF;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            state_ff <= TFP_OFF; // R13
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            shdnPrev_ff <= 1'b0;
        else
            shdnPrev_ff <= shutdownPin;
    end

    // Start-up window counted in PWM periods, restarted on entry
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || nxt_state != state_ff)
            periodCnt_ff <= '0; // R6 R10
        else if (periodEnd && periodCnt_ff != STARTUP_PERIODS)
            periodCnt_ff <= periodCnt_ff + 6'h01; // R5
    end

    // Blank sense pulses in the clock cycle in which PWM turns on
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            pwmPrev_ff <= 1'b0;
        else
            pwmPrev_ff <= pwmOut;
    end
    assign senseValid = senseIn && !(pwmOut && !pwmPrev_ff); // R8

    // Missing-pulse detector: periods since last sense pulse
    // Restarted on every state change so the retry window counts its own 32 periods
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || state_ff == TFP_OFF || state_ff == TFP_FAULT || shutdownPin)
            missCnt_ff <= '0; // R9
        else if (nxt_state != state_ff)
            missCnt_ff <= '0; // R10
        else if (senseValid)
            missCnt_ff <= '0;
        else if (periodEnd && missCnt_ff != MISS_PERIODS)
            missCnt_ff <= missCnt_ff + 6'h01; // R11
    end

    // Drive level: forced high in start windows, duty in run, low otherwise
    always_comb
    begin
        case (state_ff)
            TFP_START, TFP_RETRY:
                drive = 1'b1; // R6 R10
            TFP_RUN:
                drive = (slotIdx_ff < duty_ff); // R3 R4 R7
            default:
                drive = 1'b0; // R11 R12
        endcase
    end

    // Outputs registered; shutdown pin overrides drive and fault
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pwmOut <= 1'b0;
            faultOut_n <= 1'b1;
            overheatAlert_n <= 1'b1;
        end
        else
        begin
            pwmOut <= drive && !shutdownPin; // R16
            faultOut_n <= !(state_ff == TFP_FAULT) || shutdownPin; // R11 R14 R16
            overheatAlert_n <= !overheat_ff; // R7 R15
        end
    end

    // Events: fault entry, overheat rise, retry entry
    assign evSet[EV_FAULT] = (nxt_state == TFP_FAULT) && (state_ff != TFP_FAULT);
    assign evSet[EV_OVERHEAT] = (tempHold_ff > tripPoint) && !overheat_ff;
    assign evSet[EV_RETRY] = (nxt_state == TFP_RETRY) && (state_ff != TFP_RETRY);

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            status_ff <= '0;
        else if (avs_write && !avs_waitrequest && avs_address == REG_STATUS)
            status_ff <= (status_ff & ~avs_writedata[EV_W-1:0]) | evSet;
        else
            status_ff <= status_ff | evSet;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            mask_ff <= '0;
        else if (avs_write && !avs_waitrequest && avs_address == REG_MASK)
            mask_ff <= avs_writedata[EV_W-1:0];
    end

    assign irq = |(status_ff & mask_ff);

    // One wait cycle per access keeps read data registered
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            ackPending_ff <= 1'b0;
        else
            ackPending_ff <= (avs_read || avs_write) && !ackPending_ff;
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ackPending_ff;

    // Read mux; unmapped addresses read zero, writes there are dropped
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            avs_readdata <= '0;
        else if (avs_read && !ackPending_ff)
        begin
            case (avs_address)
                REG_STATUS: avs_readdata <= {29'h0, status_ff};
                REG_MASK: avs_readdata <= {29'h0, mask_ff};
                REG_TEMP: avs_readdata <= {24'h0, tempHold_ff};
                REG_STATE: avs_readdata <= {20'h0, duty_ff, 1'b0, state_ff, overheat_ff, shutdownPin, faultOut_n, pwmOut};
                default: avs_readdata <= '0;
            endcase
        end
    end
endmodule
`default_nettype wire

// [rtl/tfp_pkg.sv]
// Constants and types shared by the temperature fan PWM controller
package tfp_pkg;
    // Temperature code width, signed degrees C
    localparam int TEMP_W = 8;
    // System clock and PWM timebase
    localparam longint CLK_HZ = 40000000;
    localparam longint PWM_HZ = 15;
    // Each PWM period is split into ten duty slots of 10%
    localparam int SLOT_COUNT = 10;
    localparam longint SLOT_CYC_L = CLK_HZ / (PWM_HZ * SLOT_COUNT);
    localparam int SLOT_CYC = int'(SLOT_CYC_L);
    localparam int SLOT_W = 20;
    localparam logic [3:0] SLOT_LAST = 4'h9;
    // Start-up and missing-pulse windows counted in PWM periods
    localparam logic [5:0] STARTUP_PERIODS = 6'h20;
    localparam logic [5:0] MISS_PERIODS = 6'h20;
    // Overheat trip offset above full speed and release hysteresis, degrees C
    localparam logic signed [TEMP_W-1:0] OVERHEAT_OFFSET = 8'sh0A;
    localparam logic signed [TEMP_W-1:0] OVERHEAT_HYST = 8'sh05;
    // Duty in slots: 4 means 40%
    localparam logic [3:0] DUTY_OFF = 4'h0;
    localparam logic [3:0] DUTY_MIN = 4'h4;
    localparam logic [3:0] DUTY_BAND0 = 4'h5;
    localparam logic [3:0] DUTY_FULL = 4'hA;
    // Status / mask bit positions
    localparam int EV_FAULT = 0;
    localparam int EV_OVERHEAT = 1;
    localparam int EV_RETRY = 2;
    localparam int EV_W = 3;
    // Register byte addresses
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK = 4'h4;
    localparam logic [3:0] REG_TEMP = 4'h8;
    localparam logic [3:0] REG_STATE = 4'hC;
    // Operating states of the fan drive
    typedef enum logic [2:0] {TFP_OFF, TFP_START, TFP_RUN, TFP_RETRY, TFP_FAULT} tfp_state_t;
endpackage

// [verif/test_tfp_fan_ctrl.sv]
// Self-checking bench for the temperature fan PWM controller
`timescale 1ns/100ps
`default_nettype none
module test_tfp_fan_ctrl;
    import tfp_pkg::*;
    localparam int SLOT = 20;
    localparam int PER = 10 * SLOT;
    logic ref_clk, rst_n, tempValid, shutdown_request_n, stall, avs_read, avs_write;
    logic signed [7:0] junction_temperature;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, rd;
    wire logic senseIn, pwmOut, faultOut_n, overheatAlert_n, avs_waitrequest, irq;
    wire logic [31:0] avs_readdata;
    int err_count = 0;
    int compares = 0;
    int n, t;
    int corner[7] = '{24, 25, 29, 40, 41, 45, 56};
    tfp_fan_ctrl #(.LOW_THRESHOLD(8'sh19), .FULL_THRESHOLD(8'sh2D), .SLOT_CYCLES(SLOT)) i_tfp_fan_ctrl (
        .ref_clk(ref_clk), .rst_n(rst_n), .junction_temperature(junction_temperature), .tempValid(tempValid),
        .senseIn(senseIn), .shutdown_request_n(shutdown_request_n), .pwmOut(pwmOut), .faultOut_n(faultOut_n),
        .overheatAlert_n(overheatAlert_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq));
    tfp_fan_model i_tfp_fan_model (.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall), .pwmOut(pwmOut),
        .senseIn(senseIn));
    // Clock and watchdog
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (80000) @(posedge ref_clk);
        err_count++;
        $display("[ERR] %0t watchdog", $time);
        wrap_up();
    end
    task automatic wrap_up();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    // One Avalon transfer; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(negedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        @(posedge ref_clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Drive-high cycles over a window, sampled mid-cycle
    task automatic meas(input int len);
        n = 0;
        repeat (len)
        begin
            @(negedge ref_clk);
            n += (pwmOut === 1'b1);
        end
    endtask
    function automatic int expDuty(input int v);
        int d;
        d = (v < 25) ? 4 : 5;
        for (int k = 1; k <= 4; k++)
            d += (v >= 25 + 20 * k / 5);
        return (v >= 45) ? 10 : d;
    endfunction
    // Main sequence
    initial
    begin
        void'($urandom(32'h82aa));
        rst_n = 1'b0;
        tempValid = 1'b1;
        junction_temperature = 8'sh23;
        shutdown_request_n = 1'b1;
        stall = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h0, "status rst");
        bus(1'b1, 4'h2, 32'hFFFFFFFF);
        bus(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0, "unmapped");
        bus(1'b1, REG_TEMP, 32'h7F);
        bus(1'b0, REG_TEMP, 32'h0);
        chk(rd[7:0], 8'h23, "held temp");
        meas(30 * PER);
        chk(n, 30 * PER, "startup");
        $display("test startup done");
        repeat (3 * PER) @(posedge ref_clk);
        for (int i = 0; i < 9; i++)
        begin
            t = (i < 7) ? corner[i] : 10 + int'($urandom % 46);
            @(posedge ref_clk);
            junction_temperature <= t[7:0];
            repeat (2 * PER) @(posedge ref_clk);
            meas(PER);
            chk(n, expDuty(t) * SLOT, "duty");
            bus(1'b0, REG_STATE, 32'h0);
            chk(rd[11:8], expDuty(t), "duty reg");
        end
        $display("test duty done");
        // Hot die, stalled rotor, shutdown held long
        @(posedge ref_clk);
        stall <= 1'b1;
        shutdown_request_n <= 1'b0;
        junction_temperature <= 8'sh38;
        repeat (4) @(negedge ref_clk);
        chk(overheatAlert_n, 1'b0, "alert in shutdown_request_n");
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd[1], 1'b1, "alert event");
        chk(irq, 1'b0, "irq masked");
        bus(1'b1, REG_MASK, 32'h2);
        @(negedge ref_clk);
        chk(irq, 1'b1, "irq on");
        repeat (70 * PER) @(negedge ref_clk);
        chk({pwmOut, faultOut_n}, 2'b01, "shutdown_request_n outputs");
        @(posedge ref_clk);
        junction_temperature <= 8'sh33;
        repeat (4) @(negedge ref_clk);
        chk(overheatAlert_n, 1'b0, "alert hyst");
        @(posedge ref_clk);
        junction_temperature <= 8'sh32;
        repeat (4) @(negedge ref_clk);
        chk(overheatAlert_n, 1'b1, "alert free");
        bus(1'b1, REG_STATUS, 32'h2);
        @(negedge ref_clk);
        chk(irq, 1'b0, "irq clear");
        $display("test shutdown done");
        // Leave shutdown, then lose the rotor
        @(posedge ref_clk);
        junction_temperature <= 8'sh23;
        stall <= 1'b0;
        shutdown_request_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        meas(30 * PER);
        chk(n, 30 * PER, "restart");
        repeat (3 * PER) @(posedge ref_clk);
        stall <= 1'b1;
        for (n = 0; n < 70 * PER && faultOut_n !== 1'b0; n++) @(negedge ref_clk);
        chk(n >= 63 * PER && n <= 66 * PER, 1'b1, "fault delay");
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd[2:0], 3'h5, "fault events");
        @(posedge ref_clk);
        stall <= 1'b0;
        meas(5 * PER);
        chk({n[3:0], faultOut_n}, 5'h00, "latched");
        @(posedge ref_clk);
        shutdown_request_n <= 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(faultOut_n, 1'b1, "fault clear");
        @(posedge ref_clk);
        shutdown_request_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        meas(PER);
        chk(n, PER, "start after fault");
        $display("test fault done");
        wrap_up();
    end
endmodule
bind tfp_fan_ctrl tfp_fan_ctrl_assertions #(.FULL_THRESHOLD(FULL_THRESHOLD)) i_tfp_fan_ctrl_assertions (
    .ref_clk(ref_clk), .rst_n(rst_n), .junction_temperature(junction_temperature), .tempValid(tempValid),
    .shutdown_request_n(shutdown_request_n), .pwmOut(pwmOut), .faultOut_n(faultOut_n),
    .overheatAlert_n(overheatAlert_n), .avs_read(avs_read), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// [verif/tfp_fan_ctrl_assertions.sv]
// Port-level checks for the fan controller
`timescale 1ns/100ps
`default_nettype none
module tfp_fan_ctrl_assertions
#(
    parameter logic signed [7:0] FULL_THRESHOLD = 8'sh2D
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Temperature and fan link
    input wire logic signed [7:0] junction_temperature,
    input wire logic tempValid,
    input wire logic shutdown_request_n,
    input wire logic pwmOut,
    input wire logic faultOut_n,
    input wire logic overheatAlert_n,
    // Bus handshake
    input wire logic avs_read,
    input wire logic avs_waitrequest
);
    localparam int TRIP = FULL_THRESHOLD + 10;
    localparam int REL = FULL_THRESHOLD + 5;
    // Fresh codes above trip and release points; int compare avoids 8-bit wrap
    wire logic hot = tempValid && junction_temperature > TRIP;
    wire logic warm = tempValid && junction_temperature > REL;
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_shutdown_request_n_pwm_low: assert property (!shutdown_request_n |=> !pwmOut)
        else $error("pwm on in shutdown");
    chk_shutdown_request_n_fault_hi: assert property (!shutdown_request_n |=> faultOut_n)
        else $error("fault low in shutdown");
    chk_fault_pwm_off: assert property (!faultOut_n |-> !pwmOut)
        else $error("pwm on with fault");
    chk_fault_latched: assert property (!faultOut_n && shutdown_request_n |=> !faultOut_n)
        else $error("fault released");
    chk_alert_trip: assert property (hot |-> ##[1:3] !overheatAlert_n)
        else $error("alert missing");
    chk_alert_hold: assert property (warm [*3] ##0 !overheatAlert_n |=> !overheatAlert_n)
        else $error("alert released early");
    chk_alert_free: assert property ((tempValid && !warm) [*3] |=> overheatAlert_n)
        else $error("alert stuck");
    chk_bus_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus wait wrong");
    cov_alert: cover property ($fell(overheatAlert_n));
    cov_fault: cover property ($fell(faultOut_n));
    cov_restart: cover property ($rose(shutdown_request_n) ##[1:4] pwmOut);
endmodule
`default_nettype wire

// [verif/tfp_fan_model.sv]
// Behavioural fan: commutation pulses and turn-on artefacts on the sense line
`timescale 1ns/100ps
`default_nettype none
module tfp_fan_model
(
    // Clock, reset, bench control
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic stall,
    // Drive in, sense out
    input wire logic pwmOut,
    output logic senseIn
);
    logic pwmLast_ff;
    logic spin_ff;
    logic [5:0] comm_ff;
    // Previous drive level, to spot turn-on
    always_ff @(posedge ref_clk)
    begin
        pwmLast_ff <= rst_n && pwmOut;
    end
    // Pulse every 37 cycles of current; a stalled rotor gives none
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || !pwmOut || stall)
        begin
            comm_ff <= 6'h00;
            spin_ff <= 1'b0;
        end
        else
        begin
            comm_ff <= (comm_ff == 6'h24) ? 6'h00 : comm_ff + 6'h01;
            spin_ff <= (comm_ff == 6'h24);
        end
    end
    // Current step at turn-on shows even on a dead fan
    assign senseIn = (pwmOut && !pwmLast_ff) || spin_ff;
endmodule
`default_nettype wire
